// ---- logic/ocgs_cfg.svh ----
`ifndef OCGS_CFG_SVH
`define OCGS_CFG_SVH

// ----------------------------------------------------------------------------
// Counts and timing
// ----------------------------------------------------------------------------
`define OCGS_TRUNC_LIMIT       4'ha
`define OCGS_CLK_PERIOD_PS     8000
`define OCGS_HS_OFF_DELAY_PS   20000
`define OCGS_LS_ON_DELAY_PS    16000
`define OCGS_HS_OFF_CYC        ((`OCGS_HS_OFF_DELAY_PS + `OCGS_CLK_PERIOD_PS - 1) / `OCGS_CLK_PERIOD_PS)
`define OCGS_LS_ON_CYC         ((`OCGS_LS_ON_DELAY_PS + `OCGS_CLK_PERIOD_PS - 1) / `OCGS_CLK_PERIOD_PS)
`define OCGS_DLY_W             4

`endif

// ---- logic/ocgs_pkg.sv ----
package ocgs_pkg;

	typedef enum logic [2:0] {
		GATE_IDLE,
		GATE_HIGH_ON,
		GATE_HS_OFF_WAIT,
		GATE_HS_DISCHARGE,
		GATE_LS_ON_WAIT,
		GATE_LOW_ON
	} ocgs_gate_t;

endpackage : ocgs_pkg

// ---- logic/ocgs_sync.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Three-stage synchroniser, change accepted when stages two and three agree
// ----------------------------------------------------------------------------
module ocgs_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// Asynchronous level and its filtered copy
	input  wire logic async_in,
	output logic      level_out
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			level_out <= 1'b0;
		else if (s2_r == s3_r)
			level_out <= s3_r;
	end

endmodule : ocgs_sync

// ---- logic/ocgs_top.sv ----
// How it works
// - Overcurrent during on-time ends high-side early
// - Count consecutive truncated PWM cycles
// - First untruncated cycle clears the count
// - Tenth truncation drives fault output high
// - Fault latched until a supply power-cycles
// - PWM low starts high-side turn-off delay
// - High-side gate below threshold starts low-side delay
// - Low-side turns on ignoring switch node
// - Temperature reported only with both supplies good
`timescale 1ns/10ps
`include "ocgs_cfg.svh"

module ocgs_top (
	// Clock and reset
	input  wire logic SYS_CLK_IN,
	input  wire logic RST_IN,
	// Controller side
	input  wire logic PWM_IN,
	output logic      TEMP_FAULT_OUT,
	output logic      TEMP_REPORT_EN_OUT,
	// Power stage sense
	input  wire logic OVERCURRENT_IN,
	input  wire logic HS_GATE_OFF_IN,
	input  wire logic CONTROL_SUPPLY_OK_IN,
	input  wire logic DRIVER_SUPPLY_OK_IN,
	input  wire logic TEMP_LEVEL_IN,
	// Gate drive
	output logic      HIGH_GATE_DRIVE_OUT,
	output logic      LOW_GATE_DRIVE_OUT
);
	import ocgs_pkg::*;

	logic                  pwm_s;
	logic                  oc_s;
	logic                  hs_off_s;
	logic                  vc_s;
	logic                  vd_s;
	logic                  temp_s;
	logic                  pwm_d_r;
	logic                  supplies_ok;
	logic                  pwm_rise;
	logic                  pwm_fall;
	logic                  trunc_r;
	logic [3:0]            trunc_cnt_r;
	logic                  fault_r;
	ocgs_gate_t            gate_r;
	ocgs_gate_t            gate_nxt;
	logic [`OCGS_DLY_W-1:0] dly_r;

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------
	// On-time being cut short by overcurrent right now
	function automatic logic cutting_now(input ocgs_gate_t st, input logic oc);
		return (st == GATE_HIGH_ON) && oc;
	endfunction : cutting_now

	// First edge of a wait state, where its delay loads
	function automatic logic entering(input ocgs_gate_t st, input ocgs_gate_t nxt, input ocgs_gate_t wait_st);
		return (nxt == wait_st) && (st != wait_st);
	endfunction : entering

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	// Every input but SYS_CLK_IN and RST_IN crosses in, so each one costs about four cycles of latency
	ocgs_sync u_pwm (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (PWM_IN),
		.level_out (pwm_s)
	);

	ocgs_sync u_oc (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (OVERCURRENT_IN),
		.level_out (oc_s)
	);

	ocgs_sync u_hs (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (HS_GATE_OFF_IN),
		.level_out (hs_off_s)
	);

	ocgs_sync u_vc (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (CONTROL_SUPPLY_OK_IN),
		.level_out (vc_s)
	);

	ocgs_sync u_vd (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (DRIVER_SUPPLY_OK_IN),
		.level_out (vd_s)
	);

	ocgs_sync u_tm (
		.clk_in    (SYS_CLK_IN),
		.rst_in    (RST_IN),
		.async_in  (TEMP_LEVEL_IN),
		.level_out (temp_s)
	);

	assign supplies_ok = vc_s & vd_s;
	assign pwm_rise    = pwm_s & ~pwm_d_r;
	assign pwm_fall    = ~pwm_s & pwm_d_r;

	// Resets to the idle level of the pin, so no false rise follows reset
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			pwm_d_r <= 1'b0;
		else
			pwm_d_r <= pwm_s;
	end

	// ------------------------------------------------------------------------
	// Truncation tracking
	// ------------------------------------------------------------------------
	// Truncation is noted when overcurrent ends an on-time; judged at each PWM fall
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			trunc_r <= 1'b0;
		else if (pwm_rise)
			trunc_r <= 1'b0;
		else if (cutting_now(gate_r, oc_s))
			trunc_r <= 1'b1;
	end

	// Saturates at the limit, so the latch input stays asserted

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN || !supplies_ok)
			trunc_cnt_r <= 4'h0;
		else if (pwm_fall) begin
			if (trunc_r || cutting_now(gate_r, oc_s)) begin
				if (trunc_cnt_r != `OCGS_TRUNC_LIMIT)
					trunc_cnt_r <= trunc_cnt_r + 4'h1;
			end else
				trunc_cnt_r <= 4'h0;
		end
	end

	// Only a supply drop clears the latch; PWM activity never does
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			fault_r <= 1'b0;
		else if (!supplies_ok)
			fault_r <= 1'b0;
		else if (trunc_cnt_r == `OCGS_TRUNC_LIMIT)
			fault_r <= 1'b1;
	end

	// ------------------------------------------------------------------------
	// Gate sequencing
	// ------------------------------------------------------------------------
	// Limitation: a PWM rise during the discharge or low-side wait is not kept
	always_comb begin
		gate_nxt = gate_r;
		unique case (gate_r)
			GATE_IDLE:         if (supplies_ok) gate_nxt = pwm_s ? GATE_HIGH_ON : GATE_LOW_ON;
			GATE_HIGH_ON:      if (!pwm_s || oc_s) gate_nxt = GATE_HS_OFF_WAIT;
			GATE_HS_OFF_WAIT:  if (dly_r == '0) gate_nxt = GATE_HS_DISCHARGE;
			GATE_HS_DISCHARGE: if (hs_off_s) gate_nxt = GATE_LS_ON_WAIT;
			GATE_LS_ON_WAIT:   if (dly_r == '0) gate_nxt = GATE_LOW_ON;
			GATE_LOW_ON:       if (pwm_rise) gate_nxt = GATE_HIGH_ON;
		endcase
		if (!supplies_ok)
			gate_nxt = GATE_IDLE;
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			gate_r <= GATE_IDLE;
		else
			gate_r <= gate_nxt;
	end

	// Delay loads on entry to each wait state
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			dly_r <= '0;
		else if (entering(gate_r, gate_nxt, GATE_HS_OFF_WAIT))
			dly_r <= `OCGS_DLY_W'(`OCGS_HS_OFF_CYC - 1);
		else if (entering(gate_r, gate_nxt, GATE_LS_ON_WAIT))
			dly_r <= `OCGS_DLY_W'(`OCGS_LS_ON_CYC - 1);
		else if (dly_r != '0)
			dly_r <= dly_r - 1'b1;
	end

	// Low gate only after discharge confirmed, or straight from idle with PWM low, so the two never overlap
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			HIGH_GATE_DRIVE_OUT <= 1'b0;
			LOW_GATE_DRIVE_OUT  <= 1'b0;
		end else begin
			HIGH_GATE_DRIVE_OUT <= (gate_nxt == GATE_HIGH_ON) ||
			                       (gate_nxt == GATE_HS_OFF_WAIT && !pwm_s && !oc_s);
			LOW_GATE_DRIVE_OUT  <= (gate_nxt == GATE_LOW_ON);
		end
	end

	// ------------------------------------------------------------------------
	// Shared temperature and fault output
	// ------------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			TEMP_REPORT_EN_OUT <= 1'b0;
		else
			TEMP_REPORT_EN_OUT <= supplies_ok & ~fault_r;
	end

	// Fault level wins over temperature while latched
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			TEMP_FAULT_OUT <= 1'b0;
		else if (fault_r)
			TEMP_FAULT_OUT <= 1'b1;
		else
			TEMP_FAULT_OUT <= supplies_ok & temp_s;
	end

endmodule : ocgs_top

// ---- tb/ocgs_top_sva.sv ----
`timescale 1ns/10ps
module ocgs_top_sva (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// Controller side
	input wire logic PWM_IN,
	input wire logic TEMP_FAULT_OUT,
	input wire logic TEMP_REPORT_EN_OUT,
	// Power stage sense
	input wire logic OVERCURRENT_IN,
	input wire logic HS_GATE_OFF_IN,
	input wire logic CONTROL_SUPPLY_OK_IN,
	input wire logic DRIVER_SUPPLY_OK_IN,
	input wire logic TEMP_LEVEL_IN,
	// Gate drive
	input wire logic HIGH_GATE_DRIVE_OUT,
	input wire logic LOW_GATE_DRIVE_OUT
);
	wire sup = CONTROL_SUPPLY_OK_IN & DRIVER_SUPPLY_OK_IN;
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);
	chk_no_overlap: assert property (!(HIGH_GATE_DRIVE_OUT && LOW_GATE_DRIVE_OUT))
		else $error("gates overlap");
	chk_fault_hold: assert property (TEMP_FAULT_OUT && !TEMP_REPORT_EN_OUT && sup
		|=> TEMP_FAULT_OUT && !TEMP_REPORT_EN_OUT) else $error("fault dropped");
	chk_ctrl_down: assert property (!CONTROL_SUPPLY_OK_IN [*8] |-> !TEMP_FAULT_OUT && !TEMP_REPORT_EN_OUT)
		else $error("output live without control supply");
	chk_drv_down: assert property (!DRIVER_SUPPLY_OK_IN [*8] |-> !TEMP_REPORT_EN_OUT && !LOW_GATE_DRIVE_OUT)
		else $error("output live without driver supply");
	chk_oc_cut: assert property ($rose(OVERCURRENT_IN) && HIGH_GATE_DRIVE_OUT |-> ##[1:12] !HIGH_GATE_DRIVE_OUT)
		else $error("on-time not cut");
	chk_hs_delay: assert property ($fell(PWM_IN) && HIGH_GATE_DRIVE_OUT && !OVERCURRENT_IN
		|-> HIGH_GATE_DRIVE_OUT [*3] ##[1:12] !HIGH_GATE_DRIVE_OUT) else $error("high gate off timing");
	chk_ls_wait: assert property ($rose(LOW_GATE_DRIVE_OUT) |-> $past(HS_GATE_OFF_IN, 5))
		else $error("low gate before discharge");
	chk_temp_pass: assert property ((TEMP_REPORT_EN_OUT && $stable(TEMP_LEVEL_IN)) [*6] |-> TEMP_FAULT_OUT == TEMP_LEVEL_IN)
		else $error("temperature not passed through");
	chk_ls_on: assert property ($rose(HS_GATE_OFF_IN) && sup |-> ##[1:12] LOW_GATE_DRIVE_OUT)
		else $error("low gate missing");
endmodule : ocgs_top_sva
bind ocgs_top ocgs_top_sva chk (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .PWM_IN(PWM_IN),
	.OVERCURRENT_IN(OVERCURRENT_IN), .HS_GATE_OFF_IN(HS_GATE_OFF_IN), .CONTROL_SUPPLY_OK_IN(CONTROL_SUPPLY_OK_IN),
	.DRIVER_SUPPLY_OK_IN(DRIVER_SUPPLY_OK_IN), .TEMP_LEVEL_IN(TEMP_LEVEL_IN), .TEMP_FAULT_OUT(TEMP_FAULT_OUT),
	.TEMP_REPORT_EN_OUT(TEMP_REPORT_EN_OUT), .HIGH_GATE_DRIVE_OUT(HIGH_GATE_DRIVE_OUT),
	.LOW_GATE_DRIVE_OUT(LOW_GATE_DRIVE_OUT));

// ---- tb/ocgs_ctrl_model.sv ----
`timescale 1ns/10ps
module ocgs_ctrl_model (
	// Clock and start
	input  wire logic clk_in,
	input  wire logic go_in,
	// Gate command seen from the stage
	input  wire logic high_gate_in,
	// Controller and stage responses
	output logic      pwm_out,
	output logic      hs_off_out,
	output logic      done_out
);
	logic [1:0] lag_r = 2'h3;
	initial begin
		pwm_out = 0;
		done_out = 0;
	end
	// Gate discharge lags the drive, so a sequencer that skips the wait is caught
	always @(negedge clk_in) lag_r <= {lag_r[0], !high_gate_in};
	assign hs_off_out = lag_r[1];
	// One PWM period of 20 cycles on and 24 off, then a done strobe
	always begin
		@(posedge clk_in);
		if (go_in) begin
			@(negedge clk_in) pwm_out <= 1'h1;
			repeat (20) @(negedge clk_in);
			pwm_out <= 1'h0;
			repeat (24) @(negedge clk_in);
			done_out <= 1'h1;
			@(negedge clk_in) done_out <= 1'h0;
		end
	end
endmodule : ocgs_ctrl_model

// ---- tb/ocgs_top_tb.sv ----
`timescale 1ns/10ps
module ocgs_top_tb;
	logic clk = 0, rst = 1, oc = 0, cs_ok = 1, ds_ok = 1, temp = 0, go = 0, probe = 0;
	logic pwm, hs_off, done, fault, rep, hg, lg;
	logic [31:0] seed = 32'h5e9f;
	logic [3:0] exp_q[$];
	int fail_count = 0, num_checks = 0, cnt = 0;
	initial forever #4 clk = ~clk;
	ocgs_top uut (.SYS_CLK_IN(clk), .RST_IN(rst), .PWM_IN(pwm), .TEMP_FAULT_OUT(fault), .TEMP_REPORT_EN_OUT(rep),
		.OVERCURRENT_IN(oc), .HS_GATE_OFF_IN(hs_off), .CONTROL_SUPPLY_OK_IN(cs_ok), .DRIVER_SUPPLY_OK_IN(ds_ok),
		.TEMP_LEVEL_IN(temp), .HIGH_GATE_DRIVE_OUT(hg), .LOW_GATE_DRIVE_OUT(lg));
	ocgs_ctrl_model far (.clk_in(clk), .go_in(go), .high_gate_in(hg), .pwm_out(pwm), .hs_off_out(hs_off),
		.done_out(done));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task check(input logic [3:0] seen, input logic [3:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("ERROR %0t outputs %b expected %b", $time, seen, want);
		end
	endtask : check
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task note(input logic [3:0] e);
		exp_q.push_back(e);
		@(negedge clk) probe = 1;
		@(negedge clk) probe = 0;
	endtask : note
	// One PWM period; truncated ones see overcurrent mid on-time
	task cycle(input logic t);
		int i;
		seed = lfsr(seed);
		temp = seed[0];
		go = 1;
		@(negedge clk) go = 0;
		repeat (7) @(negedge clk);
		note({cnt >= 10 | temp, cnt < 10, 2'h2});
		oc = t;
		for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
		if (i == 200) begin
			fail_count++;
			tally_and_finish;
		end
		@(negedge clk) oc = 0;
		if (t) cnt++;
		else if (cnt < 10) cnt = 0;
		note({cnt >= 10 | temp, cnt < 10, 2'h1});
	endtask : cycle
	task pwr(input logic ctl);
		if (ctl) cs_ok = 0;
		else ds_ok = 0;
		repeat (10) @(negedge clk);
		note(4'h0);
		cs_ok = 1;
		ds_ok = 1;
		cnt = 0;
		repeat (10) @(negedge clk);
		note({temp, 3'h5});
	endtask : pwr
	always @(posedge probe) check({fault, rep, hg, lg}, exp_q.pop_front());
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		repeat (10) @(negedge clk);
		note({temp, 3'h5});
		repeat (9) cycle(1);
		cycle(0);
		$display("count clear done");
		repeat (10) cycle(1);
		repeat (3) cycle(seed[1]);
		$display("fault latch done");
		pwr(1);
		repeat (10) cycle(1);
		pwr(0);
		$display("power cycle done");
		tally_and_finish;
	end
endmodule : ocgs_top_tb
